// ===== core/cmcs_consts.vh
`ifndef CMCS_CONSTS_VH
`define CMCS_CONSTS_VH

// Register offsets on the plain register port
`define CMCS_OFF_CTRL1 4'h0
`define CMCS_OFF_CFG2 4'h1
`define CMCS_OFF_INTF 4'h2
`define CMCS_OFF_TXCTL 4'h3

// Control register fields
`define CMCS_REQ_HI 10
`define CMCS_REQ_LO 8
`define CMCS_CUR_HI 7
`define CMCS_CUR_LO 5
`define CMCS_WAKE_FILTER_ENABLE_BIT 14

// Transmit control fields
`define CMCS_TX_REQUEST_BIT_BIT 0
`define CMCS_TX_ABORTED_FLAG_BIT 1

// Interrupt flag fields
`define CMCS_IVR_BIT 7
`define CMCS_WAK_BIT 6
`define CMCS_ERR_BIT 5
`define CMCS_LOW_MASK 8'hEF

// Mode encodings
`define CMCS_MODE_NORMAL 3'h0
`define CMCS_MODE_DISABLE 3'h1
`define CMCS_MODE_LOOP 3'h2
`define CMCS_MODE_LISTEN 3'h3
`define CMCS_MODE_INIT 3'h4
`define CMCS_MODE_ALL 3'h7

// Reset values
`define CMCS_CTRL1_RST 3'h4

// Timing: bus idle bits, bit time, wake filter time
`define CMCS_IDLE_BITS 4'hB
`define CMCS_BIT_NS 1000
`define CMCS_CLK_NS 10
`define CMCS_WAKE_NS 500

`endif

// ===== core/cmcs_mode_ctrl.v
`timescale 1ns/10ps
`include "cmcs_consts.vh"

// Behaviour
// - Disable mode: no transmit, no receive
// - Disable mode still sets wake flag
// - Disable keeps flags and error counters
// - Disable request waits eleven recessive bits
// - Current mode bits 7:5 read 001
// - Disable mode releases pins to I/O
// - Wake filter bit 14 filters wake detection while asleep
// - New transmission waits eleven idle bits
// - Disable during wait aborts transmission
// - Code 000 selects normal bus mode
// - Listen-only: transmit pin to port I/O
// - Listen-only sends no error or ack
// - Listen-only freezes error counters
// - Code 111 ignores errors, accepts all
// - Listen-all stores partial frame data
// - Loopback routes transmit to receive internally
// - Status bits 13:8 show error states
// - Mode changes only after idle bus, or at once from disable or init
module cmcs_mode_ctrl (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire [3:0] reg_addr, // Register index
  input wire [15:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [15:0] reg_rdata, // Read data, one cycle later
  input wire bus_receive_pin, // Receive pin level
  output wire bus_transmit_pin, // Transmit pin level
  output wire bus_transmit_oe, // Transmit pin driven by block
  output wire bus_receive_owned, // Receive pin used by block
  input wire sleep_active, // Block or processor asleep
  input wire core_tx, // Protocol engine transmit bit
  output wire core_rx, // Receive bit to protocol engine
  output wire core_tx_enable, // Engine may transmit
  output wire core_rx_enable, // Engine may receive
  output wire core_err_frame_en, // Engine may send error frames
  output wire core_ack_en, // Engine may send acknowledge
  output wire core_cnt_en, // Error counters may count
  output wire core_ignore_err, // Ignore all errors
  output wire core_store_partial, // Store frame data on error
  output wire core_tx_start, // Pending transmission may start
  input wire [5:0] err_state, // Bus-off..warning levels
  input wire [7:0] event_set, // Hardware event pulses, low byte
  output wire [2:0] current_op_mode // Entered mode
);

  localparam integer BIT_CYC = `CMCS_BIT_NS / `CMCS_CLK_NS;
  localparam integer WAKE_CYC = `CMCS_WAKE_NS / `CMCS_CLK_NS;

  reg rx_meta_reg;
  reg rx_sync_reg;
  reg [2:0] requested_op_mode_reg;
  reg [2:0] cur_mode_reg;
  reg wake_filter_enable_reg;
  reg tx_request_bit_reg;
  reg tx_aborted_flag_reg;
  reg tx_wait_reg;
  reg [7:0] flags_reg;
  reg [5:0] err_prev_reg;
  reg [6:0] bit_cnt_reg;
  reg [3:0] idle_cnt_reg;
  reg [6:0] wake_cnt_reg;
  reg rx_prev_reg;
  // Per-mode permission table
  reg mode_tx_oe;
  reg mode_rx_own;
  reg mode_tx_en;
  reg mode_rx_en;
  reg mode_err_en;
  reg mode_ack_en;
  reg mode_cnt_en;
  wire bit_tick;
  wire rx_line;
  wire bus_idle;
  wire mode_active;
  wire is_dis;
  wire is_loop;
  wire is_all;
  wire is_init;
  wire wake_raw;
  wire wake_hit;
  wire err_rise;
  wire [7:0] clr_mask;
  wire abort_now;

  // Receive pin synchroniser
  always @(posedge clk)
  begin
    if (rst)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= bus_receive_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Mode decode
  assign is_dis = (cur_mode_reg == `CMCS_MODE_DISABLE);
  assign is_loop = (cur_mode_reg == `CMCS_MODE_LOOP);
  assign is_all = (cur_mode_reg == `CMCS_MODE_ALL);
  assign is_init = (cur_mode_reg == `CMCS_MODE_INIT);
  assign mode_active = ~is_dis & ~is_init;

  // Internal loop replaces the pin in loopback
  assign rx_line = is_loop ? core_tx : rx_sync_reg;

  // Bit-time enable pulse
  assign bit_tick = (bit_cnt_reg == BIT_CYC - 1);

  // Dominant level restarts the bit so idle spans whole bits
  always @(posedge clk)
  begin
    if (rst || bit_tick || !rx_line)
      bit_cnt_reg <= 7'h00;
    else
      bit_cnt_reg <= bit_cnt_reg + 7'h01;
  end

  // Count consecutive recessive bits for idle detection
  always @(posedge clk)
  begin
    if (rst)
      idle_cnt_reg <= 4'h0;
    else if (!rx_line)
      idle_cnt_reg <= 4'h0;
    else if (bit_tick && idle_cnt_reg != `CMCS_IDLE_BITS)
      idle_cnt_reg <= idle_cnt_reg + 4'h1;
  end

  assign bus_idle = (idle_cnt_reg == `CMCS_IDLE_BITS);

  // Wake detection, optional low-pass filter while asleep
  assign wake_raw = ~rx_sync_reg;

  // Dominant run length for the wake filter
  always @(posedge clk)
  begin
    if (rst || !wake_raw)
      wake_cnt_reg <= 7'h00;
    else if (wake_cnt_reg != WAKE_CYC)
      wake_cnt_reg <= wake_cnt_reg + 7'h01;
  end

  assign wake_hit = (wake_filter_enable_reg && sleep_active) ?
    (wake_cnt_reg == WAKE_CYC - 1) :
    (wake_raw && rx_prev_reg);

  // Previous pin level, idle recessive after reset
  always @(posedge clk)
  begin
    if (rst)
      rx_prev_reg <= 1'b1;
    else
      rx_prev_reg <= ~wake_raw;
  end

  // Mode change only on an idle bus or when inactive
  always @(posedge clk)
  begin
    if (rst)
      cur_mode_reg <= `CMCS_CTRL1_RST;
    else if (requested_op_mode_reg != cur_mode_reg &&
             (bus_idle || !mode_active))
      cur_mode_reg <= requested_op_mode_reg;
  end

  // Transmit wait and abort on disable request
  assign abort_now = tx_wait_reg &&
    requested_op_mode_reg == `CMCS_MODE_DISABLE;

  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_request_bit_reg <= 1'b0;
      tx_aborted_flag_reg <= 1'b0;
      tx_wait_reg <= 1'b0;
    end
    else
    begin
      if (abort_now)
      begin
        tx_request_bit_reg <= 1'b0;
        tx_aborted_flag_reg <= 1'b1;
        tx_wait_reg <= 1'b0;
      end
      else
      begin
        if (reg_wr && reg_addr == `CMCS_OFF_TXCTL)
        begin
          tx_request_bit_reg <= reg_wdata[`CMCS_TX_REQUEST_BIT_BIT];
          tx_aborted_flag_reg <= tx_aborted_flag_reg &
            reg_wdata[`CMCS_TX_ABORTED_FLAG_BIT];
          // Clearing the request also drops a pending wait
          tx_wait_reg <= reg_wdata[`CMCS_TX_REQUEST_BIT_BIT] &&
            (tx_wait_reg || !tx_request_bit_reg);
        end
        if (tx_wait_reg && bus_idle)
          tx_wait_reg <= 1'b0;
      end
    end
  end

  // Control and configuration writes
  always @(posedge clk)
  begin
    if (rst)
    begin
      requested_op_mode_reg <= `CMCS_CTRL1_RST;
      wake_filter_enable_reg <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `CMCS_OFF_CTRL1)
        requested_op_mode_reg <=
          reg_wdata[`CMCS_REQ_HI:`CMCS_REQ_LO];
      if (reg_addr == `CMCS_OFF_CFG2)
        wake_filter_enable_reg <= reg_wdata[`CMCS_WAKE_FILTER_ENABLE_BIT];
    end
  end

  // Event flags: set wins, zero write clears, disable keeps them
  assign err_rise = |(err_state & ~err_prev_reg);
  assign clr_mask = (reg_wr && reg_addr == `CMCS_OFF_INTF) ?
    ~reg_wdata[7:0] : 8'h00;

  always @(posedge clk)
  begin
    if (rst)
    begin
      flags_reg <= 8'h00;
      err_prev_reg <= 6'h00;
    end
    else
    begin
      err_prev_reg <= err_state;
      flags_reg <= ((flags_reg & ~clr_mask) | event_set |
        {1'b0, wake_hit, err_rise, 5'h00}) & `CMCS_LOW_MASK;
    end
  end

  // Register read-back, one cycle after the strobe
  always @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `CMCS_OFF_CTRL1:
          reg_rdata <= {5'h00, requested_op_mode_reg,
            cur_mode_reg, 5'h00};
        `CMCS_OFF_CFG2:
          reg_rdata <= {1'b0, wake_filter_enable_reg, 14'h0000};
        `CMCS_OFF_INTF:
          reg_rdata <= {2'h0, err_state, flags_reg};
        `CMCS_OFF_TXCTL:
          reg_rdata <= {14'h0000, tx_aborted_flag_reg,
            tx_request_bit_reg};
        default:
          reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Pin ownership and engine permissions per entered mode
  always @*
  begin
    mode_tx_oe = 1'b0;
    mode_rx_own = 1'b0;
    mode_tx_en = 1'b0;
    mode_rx_en = 1'b0;
    mode_err_en = 1'b0;
    mode_ack_en = 1'b0;
    mode_cnt_en = 1'b0;
    case (cur_mode_reg)
      `CMCS_MODE_NORMAL:
      begin
        mode_tx_oe = 1'b1;
        mode_rx_own = 1'b1;
        mode_tx_en = 1'b1;
        mode_rx_en = 1'b1;
        mode_err_en = 1'b1;
        mode_ack_en = 1'b1;
        mode_cnt_en = 1'b1;
      end
      `CMCS_MODE_LISTEN:
      begin
        mode_rx_own = 1'b1;
        mode_rx_en = 1'b1;
      end
      `CMCS_MODE_ALL:
      begin
        mode_tx_oe = 1'b1;
        mode_rx_own = 1'b1;
        mode_tx_en = 1'b1;
        mode_rx_en = 1'b1;
        mode_ack_en = 1'b1;
      end
      `CMCS_MODE_LOOP:
      begin
        mode_tx_en = 1'b1;
        mode_rx_en = 1'b1;
        mode_err_en = 1'b1;
        mode_ack_en = 1'b1;
        mode_cnt_en = 1'b1;
      end
      default:
      begin
        mode_tx_oe = 1'b0;
        mode_rx_en = 1'b0;
      end
    endcase
  end

  // Module outputs from the permission table
  assign bus_transmit_oe = mode_tx_oe;
  assign bus_transmit_pin = mode_tx_oe ? core_tx : 1'b1;
  assign bus_receive_owned = mode_rx_own;
  assign core_rx = rx_line;
  assign core_tx_enable = mode_tx_en;
  assign core_rx_enable = mode_rx_en;
  assign core_err_frame_en = mode_err_en;
  assign core_ack_en = mode_ack_en;
  assign core_cnt_en = mode_cnt_en;
  assign core_ignore_err = is_all;
  assign core_store_partial = is_all;
  assign core_tx_start = tx_request_bit_reg && !tx_wait_reg &&
    mode_tx_en;
  assign current_op_mode = cur_mode_reg;

endmodule // cmcs_mode_ctrl

// ===== bench/cmcs_bus_node.sv
`timescale 1ns/10ps
module cmcs_bus_node (
  input wire clk, // Clock
  input wire act, // Frame traffic on
  input wire dom, // Hold dominant
  output wire rxd // Bus level
);
  reg [6:0] cnt_reg = 7'h00;
  reg tog_reg = 1'b0;
  // Traffic bit flips every 100 clocks, starts dominant, still when off
  always @(posedge clk)
  begin
    if (!act)
    begin
      cnt_reg <= 7'h00;
      tog_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg == 7'h63) ? 7'h00 : cnt_reg + 7'h01;
      tog_reg <= tog_reg ^ (cnt_reg == 7'h63);
    end
  end
  // Pulled-up bus is recessive when released
  assign rxd = dom ? 1'b0 : (act ? tog_reg : 1'b1);
endmodule // cmcs_bus_node

// ===== bench/cmcs_mode_ctrl_chk.sv
`timescale 1ns/10ps
module cmcs_mode_ctrl_chk (
  input wire clk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire bus_receive_pin,
  input wire bus_transmit_pin,
  input wire bus_transmit_oe,
  input wire bus_receive_owned,
  input wire core_tx,
  input wire core_rx,
  input wire core_tx_enable,
  input wire core_rx_enable,
  input wire core_err_frame_en,
  input wire core_ack_en,
  input wire core_cnt_en,
  input wire core_ignore_err,
  input wire core_store_partial,
  input wire core_tx_start,
  input wire [5:0] err_state,
  input wire [2:0] current_op_mode
);
  reg [10:0] idle_reg;
  wire [2:0] m = current_op_mode;
  // Recessive run length seen at the pin
  always @(posedge clk)
    if (rst || !bus_receive_pin)
      idle_reg <= 11'h000;
    else if (idle_reg != 11'h7FF)
      idle_reg <= idle_reg + 11'h001;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  dis_quiet_a:
    assert property (m == 3'h1 |-> !core_tx_enable && !core_rx_enable)
      else $error("disabled block active");
  dis_pins_a:
    assert property (m == 3'h1 |-> !bus_transmit_oe && !bus_receive_owned)
      else $error("disabled block holds pins");
  norm_mode_a:
    assert property (m == 3'h0 |-> bus_transmit_oe && bus_receive_owned
      && core_tx_enable && core_rx_enable) else $error("normal mode");
  lsn_pass_a:
    assert property (m == 3'h3 |-> !bus_transmit_oe && bus_receive_owned
      && !core_err_frame_en && !core_ack_en) else $error("listen");
  lsn_cnt_a:
    assert property (m == 3'h3 |-> !core_cnt_en) else $error("counting");
  all_msg_a:
    assert property (m == 3'h7 |-> core_ignore_err && core_store_partial)
      else $error("listen all");
  loop_route_a:
    assert property (m == 3'h2 |-> core_rx == core_tx && !bus_transmit_oe
      && !bus_receive_owned) else $error("loopback");
  pin_release_a:
    assert property (!bus_transmit_oe |-> bus_transmit_pin)
      else $error("released pin not recessive");
  pin_drive_a:
    assert property (bus_transmit_oe |-> bus_transmit_pin == core_tx)
      else $error("driven pin wrong");
  idle_wait_a:
    assert property (m != $past(m) && $past(m) != 3'h1 && $past(m) != 3'h4
      |-> $past(idle_reg) >= 11'h44C) else $error("mode change early");
  tx_wait_a:
    assert property ($rose(core_tx_start) |-> idle_reg >= 11'h44C)
      else $error("transmit early");
  err_view_a:
    assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[15:8] ==
      {2'h0, $past(err_state)}) else $error("status bits");
  cover property (m == 3'h2);
  cover property (m == 3'h0 ##1 m == 3'h1);
  cover property ($rose(core_tx_start));
endmodule // cmcs_mode_ctrl_chk
bind cmcs_mode_ctrl cmcs_mode_ctrl_chk chk_i (.clk, .rst, .reg_addr,
  .reg_rd, .reg_rdata, .bus_receive_pin, .bus_transmit_pin, .bus_transmit_oe,
  .bus_receive_owned, .core_tx, .core_rx, .core_tx_enable, .core_rx_enable,
  .core_err_frame_en, .core_ack_en, .core_cnt_en, .core_ignore_err,
  .core_store_partial, .core_tx_start, .err_state, .current_op_mode);

// ===== bench/cmcs_mode_ctrl_tb.sv
`timescale 1ns/10ps
module cmcs_mode_ctrl_tb;
  logic clk, rst, reg_wr, reg_rd, sleep_active, core_tx, act, dom, errf;
  logic rx_pin, rd_seen, tx_quiet;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, exp_v;
  logic [7:0] event_set;
  logic [5:0] err_state, s;
  logic [2:0] current_op_mode;
  logic [2:0] ms [4] = '{3'h3, 3'h7, 3'h2, 3'h0};
  logic [31:0] rnd = 32'h8D40;
  logic [15:0] expq [$];
  int errors, n_tests;
  cmcs_bus_node cmcs_bus_node_i (.clk(clk), .act(act), .dom(dom),
    .rxd(rx_pin));
  cmcs_mode_ctrl cmcs_mode_ctrl_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_receive_pin(rx_pin),
    .bus_transmit_pin(), .bus_transmit_oe(), .bus_receive_owned(),
    .sleep_active(sleep_active), .core_tx(core_tx), .core_rx(),
    .core_tx_enable(), .core_rx_enable(), .core_err_frame_en(),
    .core_ack_en(), .core_cnt_en(), .core_ignore_err(),
    .core_store_partial(), .core_tx_start(), .err_state(err_state),
    .event_set(event_set), .current_op_mode(current_op_mode));
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task wait_mode(input [2:0] md);
    for (int i = 0; i < 1500 && current_op_mode !== md; i++)
      @(negedge clk);
    n_tests++;
    if (current_op_mode !== md)
    begin
      errors++;
      $display("mismatch current_op_mode exp %h got %h", md, current_op_mode);
    end
  endtask
  task finish_test;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random transmit bits and read tracking
  always @(posedge clk)
  begin
    rnd <= lfsr(rnd);
    core_tx <= rnd[0] | tx_quiet;
    rd_seen <= reg_rd;
  end
  // Compare read data against oldest note
  always @(negedge clk)
    if (rd_seen === 1'b1)
    begin
      exp_v = expq.pop_front();
      n_tests++;
      if (reg_rdata !== exp_v)
      begin
        errors++;
        $display("mismatch reg_rdata exp %h got %h", exp_v, reg_rdata);
      end
    end
  // Watchdog
  initial
  begin
    #300000;
    errors++;
    finish_test;
  end
  // Main sequence
  initial
  begin
    {rst, reg_wr, reg_rd, sleep_active, act, dom, errf, tx_quiet} = 8'h80;
    {reg_addr, reg_wdata, event_set, err_state} = '0;
    errors = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 16'h0480);
    rd(4'hF, 16'h0000);
    wr(4'h0, 16'h0000);
    wait_mode(3'h0);
    wr(4'h3, 16'h0001);
    repeat (1200) @(posedge clk);
    wr(4'h3, 16'h0000);
    foreach (ms[i])
    begin
      tx_quiet <= (ms[i] == 3'h0);
      wr(4'h0, {5'h00, ms[i], 8'h00});
      wait_mode(ms[i]);
      rd(4'h0, {5'h00, ms[i], ms[i], 5'h00});
    end
    repeat (4)
    begin
      s = rnd[5:0];
      errf = errf | (|(s & ~err_state));
      err_state <= s;
      repeat (3) @(posedge clk);
      rd(4'h2, {2'h0, s, 2'h0, errf, 5'h00});
    end
    event_set <= 8'hFF;
    @(posedge clk);
    event_set <= 8'h00;
    wr(4'h2, 16'hFFFF);
    rd(4'h2, {2'h0, s, 8'hEF});
    act <= 1'b1;
    repeat (4) @(posedge clk);
    wr(4'h3, 16'h0001);
    wr(4'h0, 16'h0100);
    repeat (600) @(posedge clk);
    rd(4'h0, 16'h0100);
    act <= 1'b0;
    wait_mode(3'h1);
    rd(4'h0, 16'h0120);
    rd(4'h3, 16'h0002);
    rd(4'h2, {2'h0, s, 8'hEF});
    wr(4'h2, 16'h0000);
    wr(4'h1, 16'h4000);
    sleep_active <= 1'b1;
    rd(4'h1, 16'h4000);
    for (int k = 20; k < 80; k += 40)
    begin
      dom <= 1'b1;
      repeat (k) @(posedge clk);
      dom <= 1'b0;
      repeat (9) @(posedge clk);
      rd(4'h2, {2'h0, s, (k > 50) ? 8'h40 : 8'h00});
    end
    sleep_active <= 1'b0;
    wr(4'h2, 16'h0000);
    dom <= 1'b1;
    repeat (3) @(posedge clk);
    dom <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'h2, {2'h0, s, 8'h40});
    repeat (2) @(posedge clk);
    finish_test;
  end
endmodule // cmcs_mode_ctrl_tb
